// >>> common/dcal_params.svh
// Constants of the DAC data and calibration register bank
// Included by the package and by the design module
`ifndef DCAL_PARAMS_SVH
`define DCAL_PARAMS_SVH

`define DCAL_ADDR_W 5
`define DCAL_DATA_W 16
`define DCAL_CODE_W 12
`define DCAL_NCHAN 8
`define DCAL_FRAME_BITS 5'h18

// Register offsets
`define DCAL_ADDR_CONFIG 5'h00
`define DCAL_ADDR_SLEEP 5'h01
`define DCAL_ADDR_STATUS 5'h02
`define DCAL_ADDR_BCAST 5'h07
`define DCAL_BASE_INPUT 5'h08
`define DCAL_BASE_OFFSET 5'h10
`define DCAL_BASE_GAIN 5'h18

// Field positions
`define DCAL_SLEEP_BIT 15
`define DCAL_SCE_BIT 0
`define DCAL_LOAD_BIT 1
`define DCAL_CODE_HI 15
`define DCAL_CODE_LO 4
`define DCAL_FRAME_RW_BIT 23

// Reset values and maximum code
`define DCAL_RST_CODE 12'h000
`define DCAL_RST_OFFSET 12'h000
`define DCAL_RST_GAIN 12'h800
`define DCAL_RST_WORD 16'h0000
`define DCAL_CODE_MAX 12'hFFF

`endif

// >>> common/dcal_pkg.sv
// Types of the DAC data and calibration register bank
// Assumes dcal_params.svh on the include path
package dcal_pkg;
	`include "dcal_params.svh"

	typedef logic [`DCAL_CODE_W-1:0] dcal_code_t;
	typedef logic [`DCAL_NCHAN-1:0][`DCAL_CODE_W-1:0] dcal_chan_bus_t;

	// One register write, from the bus or from the serial link
	typedef struct packed {
		logic [`DCAL_ADDR_W-1:0] addr;
		logic [`DCAL_DATA_W-1:0] data;
	} dcal_write_s;

	// Serial frame: read flag, two spare bits, address, data
	typedef struct packed {
		logic rd;
		logic [1:0] spare;
		dcal_write_s wr;
	} dcal_frame_s;
endpackage

// >>> rtl/dcal_regs.sv
// Register bank of an octal 12-bit DAC: sleep control, broadcast, data and calibration
// Assumes a register port on i_mclk and a serial link on its own clock i_sclk
`timescale 1ns/100ps
`include "dcal_params.svh"

module dcal_regs
	import dcal_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [`DCAL_ADDR_W-1:0] i_addr,
	input wire logic [`DCAL_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`DCAL_DATA_W-1:0] o_rdata,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	output logic o_sdo,
	input wire logic i_wake_pin_n,
	output logic o_sleep,
	output dcal_chan_bus_t o_channel_out
);

	function automatic logic chan_hit(input logic [`DCAL_ADDR_W-1:0] addr, input logic [`DCAL_ADDR_W-1:0] base);
		chan_hit = (addr[4:3] == base[4:3]);
	endfunction

	// Link domain
	logic [1:0] sleep_link_sync;
	logic [`DCAL_FRAME_BITS-1:0] shift_reg;
	logic [4:0] bit_count;
	dcal_frame_s frame_word;
	logic frame_toggle;
	logic [`DCAL_FRAME_BITS-1:0] next_shift;

	// Register domain
	logic [1:0] wake_sync;
	logic [2:0] toggle_sync;
	logic serial_pending;
	dcal_write_s serial_req;
	dcal_write_s wreq;
	logic wen;
	logic self_correction_enable;
	logic load_pulse;
	logic sleep;
	dcal_code_t new_code;
	dcal_chan_bus_t input_code;
	dcal_chan_bus_t data_code;
	dcal_chan_bus_t offset_trim;
	dcal_chan_bus_t gain_trim;
	dcal_chan_bus_t corrected;
	logic [`DCAL_NCHAN-1:0] recalc;
	logic [`DCAL_DATA_W-1:0] next_rdata;

	// Serial link on its own clock; frame ended by its 24th bit, link cleared by chip select
	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			sleep_link_sync <= 2'h0;
		end else begin
			sleep_link_sync <= {sleep_link_sync[0], sleep};
		end
	end

	assign next_shift = {shift_reg[`DCAL_FRAME_BITS-2:0], i_sdi};

	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			shift_reg <= '0;
			bit_count <= 5'h00;
		end else if (!sleep_link_sync[1]) begin
			shift_reg <= next_shift;
			bit_count <= (bit_count == `DCAL_FRAME_BITS - 5'h01) ? 5'h00 : bit_count + 5'h01;
		end
	end

	always_ff @(posedge i_sclk) begin
		if (!i_cs_n && !sleep_link_sync[1] && bit_count == `DCAL_FRAME_BITS - 5'h01) begin
			frame_word <= dcal_frame_s'(next_shift);
		end
	end

	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			frame_toggle <= 1'b0;
		end else if (!i_cs_n && !sleep_link_sync[1] && bit_count == `DCAL_FRAME_BITS - 5'h01) begin
			frame_toggle <= ~frame_toggle;
		end
	end

	assign o_sdo = sleep_link_sync[1] ? i_sdi : shift_reg[`DCAL_FRAME_BITS-1];

	// Crossings into the register domain
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wake_sync <= 2'h3;
			toggle_sync <= 3'h0;
		end else begin
			wake_sync <= {wake_sync[0], i_wake_pin_n};
			toggle_sync <= {toggle_sync[1:0], frame_toggle};
		end
	end

	// Serial write waits while the bus writes
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			serial_pending <= 1'b0;
			serial_req <= '0;
		end else if (toggle_sync[2] != toggle_sync[1] && !frame_word.rd) begin
			serial_pending <= 1'b1;
			serial_req <= frame_word.wr;
		end else if (!i_wr) begin
			serial_pending <= 1'b0;
		end
	end

	always_comb begin
		wen = i_wr || serial_pending;
		wreq = i_wr ? dcal_write_s'{addr: i_addr, data: i_wdata} : serial_req;
	end

	assign new_code = wreq.data[`DCAL_CODE_HI:`DCAL_CODE_LO];

	// Configuration: correction enable and latch load strobe
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			self_correction_enable <= 1'b0;
		end else if (wen && wreq.addr == `DCAL_ADDR_CONFIG) begin
			self_correction_enable <= wreq.data[`DCAL_SCE_BIT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			load_pulse <= 1'b0;
		end else begin
			load_pulse <= wen && wreq.addr == `DCAL_ADDR_CONFIG && wreq.data[`DCAL_LOAD_BIT];
		end
	end

	// Sleep bit; the wake pin clear wins over a set
	always_ff @(posedge i_mclk) begin
		if (i_rst || !wake_sync[1]) begin
			sleep <= 1'b0;
		end else if (wen && wreq.addr == `DCAL_ADDR_SLEEP) begin
			sleep <= wreq.data[`DCAL_SLEEP_BIT];
		end
	end

	assign o_sleep = sleep;

	// Per channel storage, correction and output latch
	generate
		for (genvar ch = 0; ch < `DCAL_NCHAN; ch++) begin : g_chan
			logic hit;
			logic [24:0] product;
			logic signed [14:0] sum;

			assign hit = chan_hit(wreq.addr, `DCAL_BASE_INPUT) && wreq.addr[2:0] == 3'(ch);

			always_comb begin
				product = 25'(input_code[ch]) * 25'({1'b0, `DCAL_RST_GAIN} + {1'b0, gain_trim[ch]});
				sum = $signed({2'b00, product[24:12]}) + 15'($signed(offset_trim[ch]));
				if (sum < 0) begin
					corrected[ch] = `DCAL_RST_CODE;
				end else if (sum > $signed({3'b000, `DCAL_CODE_MAX})) begin
					corrected[ch] = `DCAL_CODE_MAX;
				end else begin
					corrected[ch] = sum[11:0];
				end
			end

			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					input_code[ch] <= `DCAL_RST_CODE;
				end else if (wen && hit && self_correction_enable) begin
					input_code[ch] <= new_code;
				end
			end

			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					offset_trim[ch] <= `DCAL_RST_OFFSET;
					gain_trim[ch] <= `DCAL_RST_GAIN;
				end else if (wen && wreq.addr[2:0] == 3'(ch)) begin
					if (chan_hit(wreq.addr, `DCAL_BASE_OFFSET)) begin
						offset_trim[ch] <= new_code;
					end
					if (chan_hit(wreq.addr, `DCAL_BASE_GAIN)) begin
						gain_trim[ch] <= new_code;
					end
				end
			end

			// Engine recomputes one cycle after any write to its inputs while correction is enabled
			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					recalc[ch] <= 1'b0;
				end else begin
					recalc[ch] <= self_correction_enable && wen && wreq.addr[2:0] == 3'(ch) && wreq.addr[4:3] != 2'h0;
				end
			end

			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					data_code[ch] <= `DCAL_RST_CODE;
				end else if (wen && !self_correction_enable && wreq.addr == `DCAL_ADDR_BCAST) begin
					data_code[ch] <= new_code;
				end else if (wen && !self_correction_enable && hit) begin
					data_code[ch] <= new_code;
				end else if (recalc[ch] && self_correction_enable) begin
					data_code[ch] <= corrected[ch];
				end
			end

			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					o_channel_out[ch] <= `DCAL_RST_CODE;
				end else if (load_pulse) begin
					o_channel_out[ch] <= data_code[ch];
				end
			end
		end
	endgenerate

	// Read port, data one cycle after the strobe
	always_comb begin
		next_rdata = `DCAL_RST_WORD;
		if (i_addr == `DCAL_ADDR_CONFIG) begin
			next_rdata[`DCAL_SCE_BIT] = self_correction_enable;
		end else if (i_addr == `DCAL_ADDR_SLEEP) begin
			next_rdata[`DCAL_SLEEP_BIT] = sleep;
		end else if (i_addr == `DCAL_ADDR_STATUS) begin
			next_rdata = {13'h0000, serial_pending, wake_sync[1], sleep};
		end else if (i_addr == `DCAL_ADDR_BCAST) begin
			next_rdata = `DCAL_RST_WORD;
		end else if (chan_hit(i_addr, `DCAL_BASE_INPUT)) begin
			next_rdata = {self_correction_enable ? input_code[i_addr[2:0]] : data_code[i_addr[2:0]], 4'h0};
		end else if (chan_hit(i_addr, `DCAL_BASE_OFFSET)) begin
			next_rdata = {offset_trim[i_addr[2:0]], 4'h0};
		end else if (chan_hit(i_addr, `DCAL_BASE_GAIN)) begin
			next_rdata = {gain_trim[i_addr[2:0]], 4'h0};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rdata <= `DCAL_RST_WORD;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= `DCAL_RST_WORD;
		end
	end

	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	a_sleep_set_bit: assert property (
		(wen && wreq.addr == `DCAL_ADDR_SLEEP && wreq.data[`DCAL_SLEEP_BIT] && wake_sync[1])
		|=> sleep) else $error("sleep bit not set by write");

	a_sleep_wake_clear: assert property (!wake_sync[1] |=> !sleep)
		else $error("sleep bit survives wake pin low");

	a_bcast_load_all: assert property (
		(wen && !self_correction_enable && wreq.addr == `DCAL_ADDR_BCAST)
		|=> (data_code == {`DCAL_NCHAN{$past(new_code)}})) else $error("broadcast did not load all channels");

	a_bcast_drop_sce: assert property (
		(wen && self_correction_enable && wreq.addr == `DCAL_ADDR_BCAST && recalc == '0) |=> $stable(data_code))
		else $error("broadcast acted with correction on");

	a_bcast_read_zero: assert property ((i_rd && i_addr == `DCAL_ADDR_BCAST) |=> o_rdata == `DCAL_RST_WORD)
		else $error("broadcast read not zero");

	a_direct_write_ch0: assert property (
		(wen && !self_correction_enable && wreq.addr == `DCAL_BASE_INPUT) |=> data_code[0] == $past(new_code))
		else $error("direct write missed channel 0");

	a_latch_hold_out: assert property (!load_pulse |=> $stable(o_channel_out))
		else $error("output changed without latch load");

	a_reset_defaults: assert property (
		$past(i_rst) |-> (input_code == '0 && offset_trim == '0 && gain_trim == {`DCAL_NCHAN{`DCAL_RST_GAIN}}))
		else $error("reset values wrong");

	a_corrected_ch0: assert property (
		(wen && self_correction_enable && wreq.addr == `DCAL_BASE_INPUT) ##1 (self_correction_enable && !wen)
		|=> data_code[0] == $past(corrected[0])) else $error("corrected code not stored");

	a_shift_in_bit: assert property (@(posedge i_sclk) disable iff (i_cs_n || i_rst)
		!sleep_link_sync[1] |=> shift_reg[0] == $past(i_sdi))
		else $error("serial bit not shifted in");

	a_sleep_no_shift: assert property (@(posedge i_sclk) disable iff (i_cs_n || i_rst)
		sleep_link_sync[1] |=> $stable(shift_reg))
		else $error("shift register moved in sleep");

	a_offset_write_ch0: assert property (
		(wen && wreq.addr == `DCAL_BASE_OFFSET) |=> offset_trim[0] == $past(new_code))
		else $error("offset trim write missed channel 0");

	a_gain_write_ch0: assert property (
		(wen && wreq.addr == `DCAL_BASE_GAIN) |=> gain_trim[0] == $past(new_code))
		else $error("gain trim write missed channel 0");

	a_input_sce_gate: assert property (
		(wen && !self_correction_enable && wreq.addr == `DCAL_BASE_INPUT) |=> $stable(input_code[0]))
		else $error("input register written with correction off");

	a_code_field_ch0: assert property (
		(wen && !self_correction_enable && wreq.addr == `DCAL_BASE_INPUT) |=> data_code[0] == $past(wreq.data[`DCAL_CODE_HI:`DCAL_CODE_LO]))
		else $error("channel code taken from wrong bits");

	a_sleep_reset_clear: assert property ($past(i_rst) |-> !sleep)
		else $error("sleep bit set after reset");

	a_latch_load_copy: assert property (load_pulse |=> o_channel_out == $past(data_code))
		else $error("output latch did not take data");

	c_bcast: cover property (wen && !self_correction_enable && wreq.addr == `DCAL_ADDR_BCAST);
	c_sleep: cover property (!sleep ##1 sleep);
	c_correct: cover property (recalc[0] && self_correction_enable);
	c_serial: cover property (serial_pending && !i_wr);

endmodule

// >>> dv/dcal_host.sv
// Serial host model: sends 24-bit frames, MSB first
// Assumes the bench calls frame() only while the link is idle
`timescale 1ns/100ps
module dcal_host (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sdi
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_sdi = 1'b0;
		// Clean rising select clears the link
		#1 o_cs_n = 1'b1;
	end
	task automatic frame(input logic [23:0] f);
		int i;
		#2 o_cs_n = 1'b0;
		for (i = 23; i >= 0; i--) begin
			o_sdi = f[i];
			#3 o_sclk = 1'b1;
			#3 o_sclk = 1'b0;
		end
		#3 o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
	endtask
endmodule

// >>> dv/testbench.sv
// Bench: register port tasks, serial host, reference model
// Assumes dcal_regs and dcal_host; clock stops between frames
`timescale 1ns/100ps
`include "dcal_params.svh"
module testbench import dcal_pkg::*;;
	logic i_mclk, i_rst, i_wr, i_rd, i_wake_pin_n, i_sclk, i_cs_n, i_sdi, o_sdo, o_sleep;
	logic [`DCAL_ADDR_W-1:0] i_addr;
	logic [`DCAL_DATA_W-1:0] i_wdata, o_rdata, rv;
	dcal_chan_bus_t o_channel_out;
	int fail_count = 0;
	int checks_done = 0;
	int md[8], k, c, g, z, v, n, self_correction_enable;
	dcal_regs uut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sclk,
		.i_cs_n, .i_sdi, .o_sdo, .i_wake_pin_n, .o_sleep, .o_channel_out);
	dcal_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic latch;
		wr(`DCAL_ADDR_CONFIG, 16'(self_correction_enable | 2));
		repeat (2) @(posedge i_mclk);
		#1;
		for (int j = 0; j < 8; j++) chk(o_channel_out[j], 16'(md[j]));
	endtask
	function automatic int corr(int x, int gn, int of);
		int r;
		if (of > 2047) of -= 4096;
		r = ((x * (2048 + gn)) >>> 12) + of;
		return (r < 0) ? 0 : (r > 4095) ? 4095 : r;
	endfunction
	task wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#500000;
		fail_count++;
		wrap_up;
	end
	initial begin
		i_rst = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wake_pin_n = 1'b1;
		self_correction_enable = 0;
		void'($urandom(49));
		#1 i_rst = 1'b1;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (k = 0; k < 8; k++) begin
			md[k] = 0;
			rd(`DCAL_BASE_INPUT + 5'(k), rv);
			chk(rv, 16'h0000);
			rd(`DCAL_BASE_OFFSET + 5'(k), rv);
			chk(rv, 16'h0000);
			rd(`DCAL_BASE_GAIN + 5'(k), rv);
			chk(rv, 16'h8000);
		end
		rd(`DCAL_ADDR_SLEEP, rv);
		chk(rv, 16'h0000);
		rd(5'h03, rv);
		chk(rv, 16'h0000);
		v = $urandom_range(4095);
		wr(`DCAL_ADDR_BCAST, 16'(v << 4) | 16'h000F);
		rd(`DCAL_ADDR_BCAST, rv);
		chk(rv, 16'h0000);
		for (k = 0; k < 8; k++) begin
			chk(o_channel_out[k], 16'h0000);
			md[k] = v;
			rd(`DCAL_BASE_INPUT + 5'(k), rv);
			chk(rv, 16'(v << 4));
		end
		latch;
		c = $urandom_range(7);
		v = $urandom_range(4095);
		fork
			host.frame({3'b100, `DCAL_BASE_INPUT + 5'(c), 16'(v << 4)});
			for (n = 1; n <= 24; n++) begin
				@(posedge i_sclk);
				#1 chk(o_sdo, 16'(n == 24));
			end
		join
		host.frame({3'b000, `DCAL_BASE_INPUT + 5'(c), 16'(v << 4)});
		repeat (20) @(posedge i_mclk);
		md[c] = v;
		rd(`DCAL_BASE_INPUT + 5'(c), rv);
		chk(rv, 16'(v << 4));
		v = $urandom_range(4095);
		wr(`DCAL_BASE_INPUT, 16'(v << 4) | 16'h000A);
		md[0] = v;
		rd(`DCAL_BASE_INPUT, rv);
		chk(rv, 16'(v << 4));
		self_correction_enable = 1;
		wr(`DCAL_ADDR_CONFIG, 16'h0001);
		rd(`DCAL_ADDR_CONFIG, rv);
		chk(rv, 16'h0001);
		wr(`DCAL_ADDR_BCAST, 16'hFFF0);
		latch;
		for (n = 0; n < 6; n++) begin
			c = (n == 0) ? 0 : $urandom_range(7);
			g = (n == 0) ? 4095 : (n == 1) ? 0 : $urandom_range(4095);
			z = (n == 0) ? 2047 : (n == 1) ? 2048 : $urandom_range(4095);
			v = (n < 2) ? 4095 : $urandom_range(4095);
			wr(`DCAL_BASE_GAIN + 5'(c), 16'(g << 4));
			wr(`DCAL_BASE_OFFSET + 5'(c), 16'(z << 4));
			wr(`DCAL_BASE_INPUT + 5'(c), 16'(v << 4));
			md[c] = corr(v, g, z);
			rd(`DCAL_BASE_GAIN + 5'(c), rv);
			chk(rv, 16'(g << 4));
			rd(`DCAL_BASE_OFFSET + 5'(c), rv);
			chk(rv, 16'(z << 4));
			rd(`DCAL_BASE_INPUT + 5'(c), rv);
			chk(rv, 16'(v << 4));
			latch;
		end
		self_correction_enable = 0;
		wr(`DCAL_ADDR_CONFIG, 16'h0000);
		wr(`DCAL_ADDR_SLEEP, 16'h8000);
		rd(`DCAL_ADDR_SLEEP, rv);
		chk(rv, 16'h8000);
		chk(o_sleep, 16'h0001);
		rd(`DCAL_ADDR_STATUS, rv);
		chk(rv, 16'h0003);
		n = 0;
		fork
			host.frame({3'b000, `DCAL_BASE_INPUT, 16'($urandom_range(65535))});
			repeat (24) begin
				@(posedge i_sclk);
				#1 n++;
				if (n > 3) chk(o_sdo, i_sdi);
			end
		join
		repeat (20) @(posedge i_mclk);
		rd(`DCAL_BASE_INPUT, rv);
		chk(rv, 16'(md[0] << 4));
		@(posedge i_mclk);
		i_wake_pin_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		#1 chk(o_sleep, 16'h0000);
		wr(`DCAL_ADDR_SLEEP, 16'h8000);
		repeat (4) @(posedge i_mclk);
		#1 chk(o_sleep, 16'h0000);
		@(posedge i_mclk);
		i_wake_pin_n <= 1'b1;
		wr(`DCAL_ADDR_SLEEP, 16'h0000);
		repeat (4) @(posedge i_mclk);
		#1 chk(o_sleep, 16'h0000);
		wrap_up;
	end
endmodule
